// file: src/cdr_consts.svh
// Shared constants for the diagnostic/request/ack/setup message blocks
`ifndef CDR_CONSTS_SVH
`define CDR_CONSTS_SVH
// ---------------------------------------------
// Timing
// ---------------------------------------------
`define CDR_CLK_HZ           40000000
`define CDR_SETUP_TIMEOUT_MS 300
`define CDR_SETUP_PERIOD_MS  100
// ---------------------------------------------
// Identifier fields
// ---------------------------------------------
`define CDR_PRIO6       5'h18
`define CDR_PRIO3       5'h0c
`define CDR_PF_DIAG     8'hdf
`define CDR_PF_REQ      8'hea
`define CDR_PF_ACK      8'he8
`define CDR_PF_PROP     8'hef
`define CDR_GLOBAL      8'hff
`define CDR_DLC_REQ     4'h3
`define CDR_DLC_FULL    4'h8
// ---------------------------------------------
// Payload values
// ---------------------------------------------
`define CDR_NET_START   2'h1
`define CDR_NET_NOACT   2'h3
`define CDR_START_B0    8'hfd
`define CDR_FILL        8'hff
`define CDR_ACK_POS     8'h00
`define CDR_ACK_NEG     8'h01
`define CDR_ACK_DENY    8'h02
`define CDR_GFV         8'h00
`define CDR_DIAG_PGN    24'h00dfff
`define CDR_PGN_MAX     24'h01ffff
`define CDR_SETUP_ID0   8'hdd
`define CDR_SETUP_ID1   8'h00
`define CDR_BM_HI_OK    8'h00
`define CDR_IDX_MAX     8'h03
// ---------------------------------------------
// Controller register map and interrupt bits
// ---------------------------------------------
`define CDR_REG_CTRL    8'h00
`define CDR_REG_SETUP   8'h04
`define CDR_REG_REQ     8'h08
`define CDR_REG_ADDR    8'h0c
`define CDR_REG_ACK     8'h10
`define CDR_REG_ISTAT   8'h14
`define CDR_REG_IMASK   8'h18
`define CDR_CTRL_START  0
`define CDR_CTRL_REQ    1
`define CDR_CTRL_PERIOD 2
`define CDR_CTRL_SETUP  3
`define CDR_INT_ACK     0
`define CDR_INT_NACK    1
`endif

// file: src/cdr_pkg.sv
// Types and helpers shared by both ends of the message link
package cdr_pkg;
  // Device operating mode, one-hot
  typedef enum logic [2:0]
  {
    MODE_BOOT     = 3'b001,
    MODE_DISABLED = 3'b010,
    MODE_ACTIVE   = 3'b100
  } cdr_mode_t;

  // Byte n of a frame payload, byte 0 in the low lanes
  function automatic logic [7:0] cdr_byte(input logic [63:0] d, input int n);
    cdr_byte = d[8*n +: 8];
  endfunction : cdr_byte

  // Assemble a 29-bit extended identifier
  function automatic logic [28:0] cdr_id(input logic [4:0] pri, input logic [7:0] pf,
                                         input logic [7:0] ps, input logic [7:0] sa);
    cdr_id = {pri, pf, ps, sa};
  endfunction : cdr_id
endpackage : cdr_pkg

// file: src/cdr_link_if.sv
// Frame-level link between the pump node and the system controller
`timescale 1ns/1ps
interface cdr_link_if;
  logic        h2d_valid; // Controller frame, one-cycle pulse
  logic [28:0] h2d_id;    // Extended identifier
  logic [3:0]  h2d_dlc;   // Data length
  logic [63:0] h2d_data;  // Byte 0 in bits 7:0
  logic        d2h_valid; // Node frame, one-cycle pulse
  logic [28:0] d2h_id;    // Extended identifier
  logic [3:0]  d2h_dlc;   // Data length
  logic [63:0] d2h_data;  // Byte 0 in bits 7:0

  modport dev  (input h2d_valid, h2d_id, h2d_dlc, h2d_data,
                output d2h_valid, d2h_id, d2h_dlc, d2h_data);
  modport host (output h2d_valid, h2d_id, h2d_dlc, h2d_data,
                input d2h_valid, d2h_id, d2h_dlc, d2h_data);
endinterface : cdr_link_if

// file: src/cdr_timer.sv
// Restartable watchdog counter with a registered expiry level
`timescale 1ns/1ps
`include "cdr_consts.svh"
module cdr_timer #(
  parameter int unsigned LIMIT = 32'd4096 // Cycles from restart to expiry
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // Control
  input  wire logic restart_i,
  // Status
  output logic      expired_o
);
  logic [31:0] cnt; // Cycles since last restart, saturating

  // ---------------------------------------------
  // Counter
  // ---------------------------------------------
  // Saturates so that a long silence never wraps back to "fresh"
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt <= 32'h0;
    else if (restart_i)
      cnt <= 32'h0;
    else if (cnt < LIMIT - 32'd1)
      cnt <= cnt + 32'd1;
  end

  // Expiry flag, high from LIMIT cycles after the last restart
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      expired_o <= 1'b0;
    else
      expired_o <= !restart_i && (cnt >= LIMIT - 32'd1);
  end
endmodule : cdr_timer

// file: src/cdr_dev_end.sv
// Pump node end: network start, request, acknowledgment and pump setup
`timescale 1ns/1ps
`include "cdr_consts.svh"
module cdr_dev_end
  import cdr_pkg::*;
#(
  parameter int unsigned SETUP_TIMEOUT_CYC = `CDR_SETUP_TIMEOUT_MS * (`CDR_CLK_HZ / 1000)
) (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  // Link to system controller
  cdr_link_if.dev         link,
  // Node configuration
  input  wire logic [7:0] node_addr_i,
  input  wire logic       diag_start_support_i,
  input  wire logic       pump_enable_source_i,
  input  wire logic       service_cfg_index_source_i,
  // Node state
  output logic            disabled_o,
  output logic [1:0]      pump_enable_o,
  output logic [7:0]      service_cfg_index_o,
  output logic            setup_timeout_o,
  output logic            req_seen_o
);
  // ---------------------------------------------
  // Receive decode
  // ---------------------------------------------
  logic [4:0]  rx_pri;      // Priority and data page
  logic [7:0]  rx_pf;       // Format field
  logic [7:0]  rx_ps;       // Destination field
  logic [7:0]  rx_sa;       // Sender address
  logic        to_me;       // Addressed to this node or global
  logic        is_diag;     // Well-formed network start message
  logic        start_cmd;   // Start command on network one
  logic        is_req;      // Well-formed request
  logic [23:0] req_pgn;     // Requested group number
  logic        req_ok;      // Request within valid range
  logic        is_setup;    // Well-formed pump setup
  logic        bm_ok;       // Bitmap field usable
  logic        idx_ok;      // Index field usable
  logic        tmo_exp;     // Setup watchdog expiry
  cdr_mode_t   mode;        // Current mode
  cdr_mode_t   next_mode;   // Mode after this edge

  assign rx_pri = link.h2d_id[28:24];
  assign rx_pf  = link.h2d_id[23:16];
  assign rx_ps  = link.h2d_id[15:8];
  assign rx_sa  = link.h2d_id[7:0];
  assign to_me  = (rx_ps == node_addr_i) || (rx_ps == `CDR_GLOBAL);

  // Priority, format, destination and length must all match
  assign is_diag = link.h2d_valid && (rx_pri == `CDR_PRIO6) && (rx_pf == `CDR_PF_DIAG)
                 && to_me && (link.h2d_dlc == `CDR_DLC_FULL);
  // Only the network-one field is looked at; other networks ignored
  assign start_cmd = is_diag
                   && (cdr_byte(link.h2d_data, 0) & 8'h03) == {6'h00, `CDR_NET_START};

  assign is_req  = link.h2d_valid && (rx_pri == `CDR_PRIO6) && (rx_pf == `CDR_PF_REQ)
                 && to_me && (link.h2d_dlc == `CDR_DLC_REQ);
  // Group number sent least significant byte first
  assign req_pgn = {cdr_byte(link.h2d_data, 2), cdr_byte(link.h2d_data, 1),
                    cdr_byte(link.h2d_data, 0)};
  assign req_ok  = is_req && (req_pgn <= `CDR_PGN_MAX);

  assign is_setup = link.h2d_valid && (rx_pri == `CDR_PRIO3) && (rx_pf == `CDR_PF_PROP)
                  && (rx_ps == node_addr_i) && (link.h2d_dlc == `CDR_DLC_FULL)
                  && (cdr_byte(link.h2d_data, 0) == `CDR_SETUP_ID0)
                  && (cdr_byte(link.h2d_data, 1) == `CDR_SETUP_ID1);
  // High byte zero is a bitmap; reserved, error and unused codes are not
  assign bm_ok  = (cdr_byte(link.h2d_data, 3) == `CDR_BM_HI_OK);
  // Small index values only; 254 and 255 keep the old value
  assign idx_ok = (cdr_byte(link.h2d_data, 4) <= `CDR_IDX_MAX);

  // ---------------------------------------------
  // Operating mode
  // ---------------------------------------------
  // Support strap sampled in the first cycle after reset release,
  // never loaded by the asynchronous reset itself
  always_comb
  begin
    next_mode = mode;
    case (mode)
      MODE_BOOT:
        next_mode = diag_start_support_i ? MODE_DISABLED : MODE_ACTIVE;
      MODE_DISABLED:
      begin
        // Start with support leaves disabled and sends nothing
        if (start_cmd && diag_start_support_i)
          next_mode = MODE_ACTIVE;
        else if (!diag_start_support_i)
          next_mode = MODE_ACTIVE;
      end
      MODE_ACTIVE:
        next_mode = MODE_ACTIVE;
      default:
        next_mode = MODE_BOOT;
    endcase
  end

  // Mode register
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mode <= MODE_BOOT;
    else
      mode <= next_mode;
  end

  // Disabled output; also means only critical and severe errors reported
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      disabled_o <= 1'b1;
    else
      disabled_o <= (next_mode != MODE_ACTIVE);
  end

  // ---------------------------------------------
  // Acknowledgment transmit
  // ---------------------------------------------
  // Frames are one-cycle pulses; the link takes them without stalling,
  // and at most one receive frame arrives per cycle, so no queue is needed
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      link.d2h_valid <= 1'b0;
      link.d2h_id    <= 29'h0;
      link.d2h_dlc   <= 4'h0;
      link.d2h_data  <= 64'h0;
    end
    else
    begin
      link.d2h_valid <= 1'b0;
      if ((start_cmd && !diag_start_support_i) || req_ok)
      begin
        // Global ack from this node, eight bytes
        link.d2h_valid <= 1'b1;
        link.d2h_id    <= cdr_id(`CDR_PRIO6, `CDR_PF_ACK, `CDR_GLOBAL, node_addr_i);
        link.d2h_dlc   <= `CDR_DLC_FULL;
        // Negative ack: no request has a data answer in this node
        link.d2h_data  <= {(start_cmd ? `CDR_DIAG_PGN : req_pgn), rx_sa,
                           `CDR_FILL, `CDR_FILL, `CDR_GFV, `CDR_ACK_NEG};
      end
    end
  end

  // Accepted request pulse for the node's own application logic
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      req_seen_o <= 1'b0;
    else
      req_seen_o <= req_ok;
  end

  // ---------------------------------------------
  // Pump setup
  // ---------------------------------------------
  // Enable bitmap, only when its source names the bus
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pump_enable_o <= 2'h0;
    else if (is_setup && pump_enable_source_i && bm_ok)
      pump_enable_o <= 2'(cdr_byte(link.h2d_data, 2));
  end

  // Configuration index, only when its source names the bus
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      service_cfg_index_o <= 8'h00;
    else if (is_setup && service_cfg_index_source_i && idx_ok)
      service_cfg_index_o <= cdr_byte(link.h2d_data, 4);
  end

  // Watchdog restarted by every well-formed setup frame
  cdr_timer #(
    .LIMIT     (SETUP_TIMEOUT_CYC)
  ) u_setup_wd (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .restart_i (is_setup),
    .expired_o (tmo_exp)
  );

  // Timeout only matters while a bus source is selected;
  // outputs keep their last valid value meanwhile
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      setup_timeout_o <= 1'b0;
    else
      setup_timeout_o <= tmo_exp && (pump_enable_source_i || service_cfg_index_source_i);
  end
endmodule : cdr_dev_end

// file: src/cdr_host_end.sv
// System controller end: sends start, requests and periodic setup frames
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "cdr_consts.svh"
module cdr_host_end
  import cdr_pkg::*;
#(
  parameter int unsigned SETUP_PERIOD_CYC = `CDR_SETUP_PERIOD_MS * (`CDR_CLK_HZ / 1000)
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Link to pump node
  cdr_link_if.host         link,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  output logic             irq_o
);
  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  logic [15:0] bitmap;      // Enable bitmap to send
  logic [7:0]  cfg_index;   // Configuration index to send
  logic [23:0] req_pgn;     // Group number to request
  logic [7:0]  own_addr;    // Controller address
  logic [7:0]  dev_addr;    // Node address
  logic        period_en;   // Periodic setup repeat
  logic [7:0]  ack_ctrl;    // Last ack control byte
  logic [23:0] ack_pgn;     // Last ack group number
  logic [1:0]  istat;       // Sticky events
  logic [1:0]  imask;       // Event enables
  logic        start_pend;  // Start frame waiting
  logic        req_pend;    // Request waiting
  logic        setup_pend;  // Setup frame waiting
  logic        per_exp;     // Period elapsed
  logic        ack_rx;      // Ack for this controller
  logic [1:0]  ev;          // Events this cycle
  logic        wr_ctrl;     // Write to control register

  assign wr_ctrl = wr_i && (addr_i == `CDR_REG_CTRL);
  assign ack_rx  = link.d2h_valid && (link.d2h_id[23:16] == `CDR_PF_ACK)
                 && (cdr_byte(link.d2h_data, 4) == own_addr);
  assign ev      = {ack_rx && (cdr_byte(link.d2h_data, 0) != `CDR_ACK_POS),
                    ack_rx && (cdr_byte(link.d2h_data, 0) == `CDR_ACK_POS)};

  // Plain configuration registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bitmap <= 16'h0; cfg_index <= 8'h0; req_pgn <= 24'h0;
      own_addr <= 8'h0; dev_addr <= 8'h0; period_en <= 1'b0; imask <= 2'h0;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `CDR_REG_CTRL:  period_en <= wdata_i[`CDR_CTRL_PERIOD];
        `CDR_REG_SETUP: {cfg_index, bitmap} <= wdata_i[23:0];
        `CDR_REG_REQ:   req_pgn <= wdata_i[23:0];
        `CDR_REG_ADDR:  {dev_addr, own_addr} <= wdata_i[15:0];
        `CDR_REG_IMASK: imask <= wdata_i[1:0];
        default:        ;
      endcase
    end
  end

  // Last received ack for this controller
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      {ack_pgn, ack_ctrl} <= 32'h0;
    else if (ack_rx)
      {ack_pgn, ack_ctrl} <= {link.d2h_data[63:40], link.d2h_data[7:0]};
  end

  // Sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      istat <= 2'h0;
    else if (wr_i && (addr_i == `CDR_REG_ISTAT))
      istat <= (istat & ~wdata_i[1:0]) | ev;
    else
      istat <= istat | ev;
  end

  // Level interrupt, registered one cycle behind the status
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(istat & imask);
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 32'h0;
    else if (!rd_i)
      rdata_o <= 32'h0;
    else
    begin
      case (addr_i)
        `CDR_REG_CTRL:  rdata_o <= {28'h0, setup_pend, period_en, req_pend, start_pend};
        `CDR_REG_SETUP: rdata_o <= {8'h0, cfg_index, bitmap};
        `CDR_REG_REQ:   rdata_o <= {8'h0, req_pgn};
        `CDR_REG_ADDR:  rdata_o <= {16'h0, dev_addr, own_addr};
        `CDR_REG_ACK:   rdata_o <= {ack_pgn, ack_ctrl};
        `CDR_REG_ISTAT: rdata_o <= {30'h0, istat};
        `CDR_REG_IMASK: rdata_o <= {30'h0, imask};
        default:        rdata_o <= 32'h0;
      endcase
    end
  end

  // ---------------------------------------------
  // Transmit scheduling
  // ---------------------------------------------
  // Repeat period counted from the last setup send
  cdr_timer #(
    .LIMIT     (SETUP_PERIOD_CYC)
  ) u_period (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .restart_i (setup_pend),
    .expired_o (per_exp)
  );

  // Pending flags; start beats request beats setup, one frame a cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      {start_pend, req_pend, setup_pend} <= 3'h0;
    else
    begin
      if (wr_ctrl && wdata_i[`CDR_CTRL_START])
        start_pend <= 1'b1;
      else
        start_pend <= 1'b0;
      if (wr_ctrl && wdata_i[`CDR_CTRL_REQ])
        req_pend <= 1'b1;
      else if (!start_pend)
        req_pend <= 1'b0;
      // Bus-selected sources need the frame repeated in time
      if ((wr_ctrl && wdata_i[`CDR_CTRL_SETUP]) || (per_exp && period_en && !setup_pend))
        setup_pend <= 1'b1;
      else if (!start_pend && !req_pend)
        setup_pend <= 1'b0;
    end
  end

  // Frame builder
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      link.h2d_valid <= 1'b0;
      link.h2d_id    <= 29'h0;
      link.h2d_dlc   <= 4'h0;
      link.h2d_data  <= 64'h0;
    end
    else
    begin
      link.h2d_valid <= start_pend || req_pend || setup_pend;
      if (start_pend)
      begin
        // Start broadcast on network one, rest all ones
        link.h2d_id   <= cdr_id(`CDR_PRIO6, `CDR_PF_DIAG, `CDR_GLOBAL, own_addr);
        link.h2d_dlc  <= `CDR_DLC_FULL;
        link.h2d_data <= {{7{`CDR_FILL}}, `CDR_START_B0};
      end
      else if (req_pend)
      begin
        link.h2d_id   <= cdr_id(`CDR_PRIO6, `CDR_PF_REQ, dev_addr, own_addr);
        link.h2d_dlc  <= `CDR_DLC_REQ;
        link.h2d_data <= {{5{`CDR_FILL}}, req_pgn};
      end
      else if (setup_pend)
      begin
        link.h2d_id   <= cdr_id(`CDR_PRIO3, `CDR_PF_PROP, dev_addr, own_addr);
        link.h2d_dlc  <= `CDR_DLC_FULL;
        link.h2d_data <= {{3{`CDR_FILL}}, cfg_index, bitmap[15:8], bitmap[7:0],
                          `CDR_SETUP_ID1, `CDR_SETUP_ID0};
      end
    end
  end
endmodule : cdr_host_end

// file: tb/cdr_link_assertions.sv
// Checker for frames on the link between controller and node
`timescale 1ns/1ps
module cdr_link_assertions #(
  parameter logic [7:0] NODE = 8'h40 // Node address on this link
) (
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  // Controller to node
  input wire logic        h2d_valid,
  input wire logic [28:0] h2d_id,
  input wire logic [3:0]  h2d_dlc,
  input wire logic [63:0] h2d_data,
  // Node to controller
  input wire logic        d2h_valid,
  input wire logic [28:0] d2h_id,
  input wire logic [3:0]  d2h_dlc,
  input wire logic [63:0] d2h_data
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // -------------------------------------------
  // Frame decode helpers
  // -------------------------------------------
  wire req    = h2d_valid && h2d_id[28:16] == {5'h18, 8'hea} && h2d_dlc == 4'h3
                && (h2d_id[15:8] == NODE || h2d_id[15:8] == 8'hff); // Request to us
  wire in_rng = h2d_data[23:0] <= 24'h01ffff; // Group number limit
  // -------------------------------------------
  // Properties
  // -------------------------------------------
  property p_req_ack;
    req && in_rng |=> d2h_valid && d2h_data[63:32] == {$past(h2d_data[23:0]), $past(h2d_id[7:0])};
  endproperty
  a_req_ack: assert property (p_req_ack) else $error("request not answered");
  property p_req_oor;
    req && !in_rng |=> !d2h_valid;
  endproperty
  a_req_oor: assert property (p_req_oor) else $error("bad request answered");
  property p_ack_id;
    d2h_valid |-> d2h_id == {5'h18, 8'he8, 8'hff, NODE} && d2h_dlc == 4'h8;
  endproperty
  a_ack_id: assert property (p_ack_id) else $error("ack identifier wrong");
  property p_ack_layout;
    d2h_valid |-> d2h_data[31:8] == 24'hffff00 && d2h_data[7:0] <= 8'h02;
  endproperty
  a_ack_layout: assert property (p_ack_layout) else $error("ack layout wrong");
  // Ack only as a reply to a frame just taken
  property p_ack_cause;
    d2h_valid |-> $past(h2d_valid);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without frame");
  property p_ack_hold;
    !d2h_valid |-> $stable(d2h_data) && $stable(d2h_id);
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack fields moved");
  // Start nack only for a start command of value one
  property p_start_nack;
    d2h_valid && d2h_data[63:40] == 24'h00dfff
      |-> $past(h2d_id[23:16]) == 8'hdf && $past(h2d_data[1:0]) == 2'h1;
  endproperty
  a_start_nack: assert property (p_start_nack) else $error("start nack cause");
  property p_start_frame;
    h2d_valid && h2d_id[23:16] == 8'hdf |-> h2d_data[7:0] == 8'hfd && h2d_dlc == 4'h8;
  endproperty
  a_start_frame: assert property (p_start_frame) else $error("start frame form");
  property p_setup_frame;
    h2d_valid && h2d_id[23:16] == 8'hef
      |-> h2d_id[28:24] == 5'h0c && h2d_data[15:0] == 16'h00dd && h2d_dlc == 4'h8;
  endproperty
  a_setup_frame: assert property (p_setup_frame) else $error("setup frame form");
  // Main traffic seen
  c_ack: cover property (d2h_valid);
  c_start: cover property (h2d_valid && h2d_id[23:16] == 8'hdf);
  c_setup: cover property (h2d_valid && h2d_id[23:16] == 8'hef);
endmodule : cdr_link_assertions

// file: tb/can_diag_request_ack_setup_test.sv
// Bench for controller and node ends of the message link
`timescale 1ns/1ps
module can_diag_request_ack_setup_test;
  import cdr_pkg::*;
  // Clock, reset, tallies
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  int          n_fail    = 0;
  int          n_checks  = 0;
  // Controller register port
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        rd_d  = 1'b0;
  logic [31:0] rdata;
  logic        irq;
  // Node pins: entry 0 faces the controller, entry 1 the bench
  logic [1:0]  support = 2'b01;
  logic [1:0]  src     = 2'b01;
  logic [1:0]  dis;
  logic [1:0]  tmo;
  logic [1:0]  seen;
  logic [1:0]  pen [2];
  logic [7:0]  idx [2];
  // Expected results, oldest first
  logic [31:0] rd_q [$];
  logic [96:0] fr_q [$];
  cdr_link_if  lk [2] ();
  // -------------------------------------------
  // Design ends and checker
  // -------------------------------------------
  cdr_host_end #(.SETUP_PERIOD_CYC(50)) cdr_host_end_inst (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .link(lk[0]), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .irq_o(irq));
  for (genvar g = 0; g < 2; g++)
  begin : g_dev
    cdr_dev_end #(.SETUP_TIMEOUT_CYC(200)) cdr_dev_end_inst (.ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i), .link(lk[g]), .node_addr_i(8'(8'h40 + g)),
      .diag_start_support_i(support[g]), .pump_enable_source_i(src[g]),
      .service_cfg_index_source_i(src[g]), .disabled_o(dis[g]), .pump_enable_o(pen[g]),
      .service_cfg_index_o(idx[g]), .setup_timeout_o(tmo[g]), .req_seen_o(seen[g]));
  end
  cdr_link_assertions #(.NODE(8'h40)) cdr_link_assertions_inst (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .h2d_valid(lk[0].h2d_valid), .h2d_id(lk[0].h2d_id),
    .h2d_dlc(lk[0].h2d_dlc), .h2d_data(lk[0].h2d_data), .d2h_valid(lk[0].d2h_valid),
    .d2h_id(lk[0].d2h_id), .d2h_dlc(lk[0].d2h_dlc), .d2h_data(lk[0].d2h_data));
  always #12.5 ref_clk_i = ~ref_clk_i;
  // -------------------------------------------
  // Tasks
  // -------------------------------------------
  task automatic chk(input string what, input logic [96:0] exp, input logic [96:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  // One strobe cycle, then release; a gap keeps strobes single
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    @(posedge ref_clk_i);
    wr    <= 1'b0;
    rd    <= 1'b0;
  endtask : bus
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd_reg
  task automatic cmd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] c);
    bus(1'b1, a, d);
    bus(1'b1, 8'h00, c);
    repeat (5) @(posedge ref_clk_i);
  endtask : cmd
  // Frame from the bench in the controller's place
  task automatic send(input logic [28:0] id, input logic [3:0] dlc, input logic [63:0] d);
    @(posedge ref_clk_i);
    lk[1].h2d_valid <= 1'b1;
    lk[1].h2d_id    <= id;
    lk[1].h2d_dlc   <= dlc;
    lk[1].h2d_data  <= d;
  endtask : send
  function automatic logic [96:0] nack(input logic [7:0] sa, input logic [23:0] pgn);
    return {5'h18, 8'he8, 8'hff, 8'h41, 4'h8, pgn, sa, 24'hffff00, 8'h01};
  endfunction : nack
  task automatic end_of_test();
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // -------------------------------------------
  // Scoreboard: read data and bench-link acks
  // -------------------------------------------
  always @(posedge ref_clk_i)
  begin
    rd_d <= rd;
    if (rd_d === 1'b1)
      chk("rdata", rd_q.pop_front(), rdata);
    if (lk[1].d2h_valid === 1'b1)
      chk("ack frame", fr_q.pop_front(), {lk[1].d2h_id, lk[1].d2h_dlc, lk[1].d2h_data});
  end
  // Hang guard, well beyond the planned run
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    end_of_test();
  end
  // -------------------------------------------
  // Main sequence
  // -------------------------------------------
  initial
  begin
    logic [23:0] p;
    logic [1:0]  b;
    logic [7:0]  i;
    void'($urandom(32'h05a6));
    lk[1].h2d_valid = 1'b0;
    lk[1].h2d_id    = 29'h0;
    lk[1].h2d_dlc   = 4'h0;
    lk[1].h2d_data  = 64'h0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk("disabled", 1, dis[0]);
    rd_reg(8'h1c, 32'h0);
    bus(1'b1, 8'h0c, 32'h00004020);
    cmd(8'h18, 32'h0, 32'h1);
    chk("disabled", 0, dis[0]);
    rd_reg(8'h14, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      p = 24'($urandom % 32'hd000);
      cmd(8'h08, {8'h00, p}, 32'h2);
      rd_reg(8'h10, {p, 8'h01});
      chk("masked irq", 0, irq);
    end
    rd_reg(8'h14, 32'h2);
    cmd(8'h18, 32'h2, 32'h0);
    chk("irq", 1, irq);
    cmd(8'h14, 32'h2, 32'h0);
    chk("irq", 0, irq);
    cmd(8'h08, 32'h00020000, 32'h2);
    rd_reg(8'h14, 32'h0);
    for (int k = 0; k < 3; k++)
    begin
      b = 2'($urandom % 4);
      i = 8'($urandom % 4);
      cmd(8'h04, {8'h00, i, 14'h0, b}, 32'h8);
      chk("enable", b, pen[0]);
      chk("index", i, idx[0]);
    end
    cmd(8'h04, 32'h00fefe03, 32'h8);
    cmd(8'h04, 32'h00040100, 32'h4);
    chk("kept", {i, 6'h0, b}, {idx[0], 6'h0, pen[0]});
    for (int c = 0; c < 4; c++)
    begin
      if (c == 1)
        fr_q.push_back(nack(8'h30, 24'h00dfff));
      send({5'h18, 8'hdf, 8'hff, 8'h30}, 4'h8, {62'h3fffffffffffffff, 2'(c)});
    end
    send({5'h18, 8'hdf, 8'h42, 8'h30}, 4'h8, 64'hfffffffffffffffd);
    fr_q.push_back(nack(8'h31, 24'h01ffff));
    send({5'h18, 8'hea, 8'h41, 8'h31}, 4'h3, 64'h01ffff);
    send({5'h18, 8'hea, 8'h41, 8'h31}, 4'h3, 64'h020000);
    send({5'h18, 8'hea, 8'h41, 8'h31}, 4'h4, 64'h000100);
    chk("request seen", 1, seen[1]);
    fr_q.push_back(nack(8'h32, 24'h000100));
    send({5'h18, 8'hea, 8'hff, 8'h32}, 4'h3, 64'h000100);
    send({5'h0c, 8'hef, 8'h41, 8'h30}, 4'h8, 64'hffffff02000300dd);
    send({5'h0c, 8'hef, 8'h41, 8'h30}, 4'h8, 64'hffffff01000210dd);
    @(posedge ref_clk_i);
    lk[1].h2d_valid <= 1'b0;
    lk[1].h2d_data  <= 64'h5a5a5a5a5a5a5a5a;
    src[1]           <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk("source off", 0, pen[1]);
    send({5'h0c, 8'hef, 8'h41, 8'h30}, 4'h8, 64'hffffff01000210dd);
    send({5'h0c, 8'hef, 8'h41, 8'h30}, 4'h8, 64'hffffff02000300dd);
    @(posedge ref_clk_i);
    lk[1].h2d_valid <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk("bench setup", {8'h02, 2'h3}, {idx[1], pen[1]});
    chk("start nack", 0, dis[1]);
    repeat (300) @(posedge ref_clk_i);
    chk("timeout", 0, tmo[0]);
    bus(1'b1, 8'h00, 32'h0);
    repeat (210) @(posedge ref_clk_i);
    chk("timeout", 2'b11, tmo);
    support[0] <= 1'b0;
    cmd(8'h18, 32'h2, 32'h9);
    chk("timeout", 0, tmo[0]);
    rd_reg(8'h10, 32'h00dfff01);
    repeat (3) @(posedge ref_clk_i);
    end_of_test();
  end
endmodule : can_diag_request_ack_setup_test
